// >>> hdl/pbus_dev.sv
// Device end: register slave with interrupt chain
`timescale 1ns/10ps
`default_nettype none
module pbus_dev
  import pbus_pkg::*;
#(
  parameter logic [DEV_W-1:0] DEV_ADDR = 10'h200,
  parameter logic [5:0]       VEC_BASE = 6'h10
)(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_b,
  // Bus side
  pbus_if.device                 bus,
  // User side: register contents and interrupt sources
  output logic [pbus_pkg::DAL_W-1:0] o_reg0,
  output logic [pbus_pkg::DAL_W-1:0] o_reg1,
  output logic [pbus_pkg::DAL_W-1:0] o_reg2,
  output logic [pbus_pkg::DAL_W-1:0] o_reg3,
  input  wire logic              i_rx_flag,
  input  wire logic              i_tx_flag,
  input  wire logic              i_rx_ie,
  input  wire logic              i_tx_ie,
  output logic                   o_iak_rx,
  output logic                   o_iak_tx
);
  import pbus_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dev_st_t          st_ff, nxt_st;
  logic [1:0]       sel_ff, nxt_sel;
  logic             bsel_ff, nxt_bsel;
  logic [DAL_W-1:0] regs_ff [NREG];
  logic [DAL_W-1:0] nxt_regs [NREG];
  logic             rply_ff, nxt_rply;
  logic             oe_ff, nxt_oe;
  logic [DAL_W-1:0] dout_ff, nxt_dout;
  logic             ack_tx_ff, nxt_ack_tx;
  logic             ack_rx_ff, nxt_ack_rx;
  logic             req_rx, req_tx, req_any, hit;

  // Request only while enable and flag both set
  assign req_rx  = i_rx_ie & i_rx_flag;
  assign req_tx  = i_tx_ie & i_tx_flag;
  assign req_any = req_rx | req_tx;
  assign bus.irq = req_any;
  // Chain passes grant when idle, blocks it when requesting
  assign bus.iak_o = bus.iak_m & ~req_any;

  // Address match within the top page
  assign hit = bus.bank7 &&
      bus.dal[DEV_LO +: DEV_W] == DEV_ADDR;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_sel    = sel_ff;
    nxt_bsel   = bsel_ff;
    nxt_regs   = regs_ff;
    nxt_rply   = rply_ff;
    nxt_oe     = oe_ff;
    nxt_dout   = dout_ff;
    nxt_ack_tx = 1'b0;
    nxt_ack_rx = 1'b0;
    case (st_ff)
      D_IDLE:
      begin
        nxt_rply = 1'b0;
        nxt_oe   = 1'b0;
        // Sync edge latches address; data-in with acknowledge, while requesting, is a grant
        if (bus.sync && hit)
        begin
          nxt_sel  = bus.dal[RSEL_LO +: 2];
          nxt_bsel = bus.dal[BYTE_B];
          nxt_st   = D_ADDR;
        end
        else if (bus.sync)
          nxt_st = D_HOLD;
        else if (bus.din && bus.iak_m && req_any)
        begin
          // Strap bits sit above the source bit; the rest read as zero
          nxt_dout                 = '0;
          nxt_dout[VEC_XMT+1 +: 6] = VEC_BASE;
          nxt_dout[VEC_XMT]        = req_tx;
          nxt_oe   = 1'b1;
          nxt_rply = 1'b1;
          nxt_ack_tx = req_tx;
          nxt_ack_rx = ~req_tx;
          nxt_st   = D_IACK;
        end
      end
      D_ADDR:
      begin
        // Selection kept across read and write of one cycle
        if (!bus.sync)
          nxt_st = D_IDLE;
        else if (bus.din && !rply_ff)
        begin
          nxt_dout = regs_ff[sel_ff];
          nxt_oe   = 1'b1;
          nxt_rply = 1'b1;
          nxt_st   = D_RD;
        end
        else if (bus.dout && !rply_ff)
        begin
          if (!bus.wtbt)
            nxt_regs[sel_ff] = bus.dal;
          else if (bsel_ff)
            nxt_regs[sel_ff][15:8] = bus.dal[15:8];
          else
            nxt_regs[sel_ff][7:0] = bus.dal[7:0];
          nxt_rply = 1'b1;
          nxt_st   = D_WR;
        end
      end
      D_RD:
        // Hold data and reply until the master takes data-in away
        if (!bus.din || !bus.sync)
        begin
          nxt_rply = 1'b0;
          nxt_oe   = 1'b0;
          nxt_st   = bus.sync ? D_ADDR : D_IDLE;
        end
      D_WR:
        // Reply stands until data-out drops, selection survives
        if (!bus.dout || !bus.sync)
        begin
          nxt_rply = 1'b0;
          nxt_st   = bus.sync ? D_ADDR : D_IDLE;
        end
      D_HOLD:
        // Someone else's cycle: stay deaf until sync drops
        if (!bus.sync)
          nxt_st = D_IDLE;
      D_IACK:
        // Vector stands until the grant's data-in is withdrawn
        if (!bus.din)
        begin
          nxt_rply = 1'b0;
          nxt_oe   = 1'b0;
          nxt_st   = D_IDLE;
        end
      default:
        nxt_st = D_IDLE;
    endcase
    // Bus init returns everything to its start state
    if (bus.init)
    begin
      nxt_st   = D_IDLE;
      nxt_rply = 1'b0;
      nxt_oe   = 1'b0;
      nxt_sel  = 2'b00;
      nxt_bsel = 1'b0;
      nxt_dout = '0;
      nxt_ack_tx = 1'b0;
      nxt_ack_rx = 1'b0;
      for (int i = 0; i < NREG; i++)
        nxt_regs[i] = REG_RST;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_ff     <= D_IDLE;
      sel_ff    <= 2'b00;
      bsel_ff   <= 1'b0;
      rply_ff   <= 1'b0;
      oe_ff     <= 1'b0;
      dout_ff   <= '0;
      ack_tx_ff <= 1'b0;
      ack_rx_ff <= 1'b0;
      for (int i = 0; i < NREG; i++)
        regs_ff[i] <= REG_RST;
    end
    else
    begin
      st_ff     <= nxt_st;
      sel_ff    <= nxt_sel;
      bsel_ff   <= nxt_bsel;
      rply_ff   <= nxt_rply;
      oe_ff     <= nxt_oe;
      dout_ff   <= nxt_dout;
      ack_tx_ff <= nxt_ack_tx;
      ack_rx_ff <= nxt_ack_rx;
      regs_ff   <= nxt_regs;
    end
  end

  // Outputs
  assign bus.rply     = rply_ff;
  assign bus.dal_s_o  = dout_ff;
  assign bus.dal_s_oe = oe_ff;
  assign o_reg0   = regs_ff[0];
  assign o_reg1   = regs_ff[1];
  assign o_reg2   = regs_ff[2];
  assign o_reg3   = regs_ff[3];
  assign o_iak_tx = ack_tx_ff;
  assign o_iak_rx = ack_rx_ff;
endmodule
`default_nettype wire

// >>> hdl/pbus_if.sv
// Interface joining bus master and device slave
`timescale 1ns/10ps
`default_nettype none
interface pbus_if;
  import pbus_pkg::*;
  // Master-driven lines, asserted = 1
  logic             init;
  logic             bank7;
  logic             sync;
  logic             din;
  logic             dout;
  logic             wtbt;
  logic             iak_m;
  // Device-driven lines
  logic             irq;
  logic             iak_o;
  logic             rply;
  // Shared data/address lines, two signals per party
  logic [DAL_W-1:0] dal_m_o;
  logic             dal_m_oe;
  logic [DAL_W-1:0] dal_s_o;
  logic             dal_s_oe;
  logic [DAL_W-1:0] dal;
  // Resolved wire level, device wins only when master released
  assign dal = dal_m_oe ? dal_m_o : (dal_s_oe ? dal_s_o : '0);

  modport master (output init, bank7, sync, din, dout, wtbt, iak_m,
                  dal_m_o, dal_m_oe, input irq, rply, dal);
  modport device (input init, bank7, sync, din, dout, wtbt, iak_m,
                  dal, output irq, iak_o, rply, dal_s_o, dal_s_oe);
endinterface
`default_nettype wire

// >>> hdl/pbus_mst.sv
// Master end: processor-side sequencer for bus cycles
`timescale 1ns/10ps
`default_nettype none
module pbus_mst
  import pbus_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_b,
  // Bus side
  pbus_if.master                     bus,
  // User side: request
  input  wire logic                  i_init,
  input  wire logic                  i_req,
  input  wire logic                  i_wr,
  input  wire logic                  i_rmw,
  input  wire logic                  i_byte,
  input  wire logic                  i_prio,
  input  wire logic [pbus_pkg::DAL_W-1:0] i_addr,
  input  wire logic [pbus_pkg::DAL_W-1:0] i_wdata,
  // User side: answer
  output logic                       o_busy,
  output logic                       o_done,
  output logic                       o_ivec,
  output logic [pbus_pkg::DAL_W-1:0] o_rdata
);
  import pbus_pkg::*;

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  mst_st_t          st_ff, nxt_st;
  logic             wr_ff, nxt_wr, rmw_ff, nxt_rmw, byte_ff, nxt_byte;
  logic [DAL_W-1:0] a_ff, nxt_a, w_ff, nxt_w, r_ff, nxt_r;
  logic             done_ff, nxt_done, ivec_ff, nxt_ivec;

  // Next state: one cycle at a time, grants only taken when idle
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_wr   = wr_ff;
    nxt_rmw  = rmw_ff;
    nxt_byte = byte_ff;
    nxt_a    = a_ff;
    nxt_w    = w_ff;
    nxt_r    = r_ff;
    nxt_done = 1'b0;
    nxt_ivec = 1'b0;
    case (st_ff)
      M_IDLE:
        if (i_req)
        begin
          nxt_wr   = i_wr;
          nxt_rmw  = i_rmw;
          nxt_byte = i_byte;
          nxt_a    = i_addr;
          nxt_w    = i_wdata;
          nxt_st   = M_BS;
        end
        else if (bus.irq && !i_prio)
          nxt_st = M_IAK;
      M_BS:
        nxt_st = M_SYNC;
      M_SYNC:
        nxt_st = (wr_ff && !rmw_ff) ? M_DOUT : M_DIN;
      M_DIN:
        if (bus.rply)
        begin
          nxt_r  = bus.dal;
          nxt_st = M_DINW;
        end
      M_DINW:
        if (!bus.rply)
          nxt_st = rmw_ff ? M_DOUT : M_END;
      M_DOUT:
        if (bus.rply)
          nxt_st = M_DOUTW;
      M_DOUTW:
        if (!bus.rply)
          nxt_st = M_END;
      M_END:
      begin
        nxt_done = 1'b1;
        nxt_st   = M_IDLE;
      end
      M_IAK:
        if (bus.rply)
        begin
          nxt_r  = bus.dal;
          nxt_st = M_IAKW;
        end
      // Vector flag leads the done pulse by one cycle
      M_IAKW:
        if (!bus.rply)
        begin
          nxt_ivec = 1'b1;
          nxt_st   = M_END;
        end
      default:
        nxt_st = M_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_ff   <= M_IDLE;
      wr_ff   <= 1'b0;
      rmw_ff  <= 1'b0;
      byte_ff <= 1'b0;
      a_ff    <= '0;
      w_ff    <= '0;
      r_ff    <= '0;
      done_ff <= 1'b0;
      ivec_ff <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      wr_ff   <= nxt_wr;
      rmw_ff  <= nxt_rmw;
      byte_ff <= nxt_byte;
      a_ff    <= nxt_a;
      w_ff    <= nxt_w;
      r_ff    <= nxt_r;
      done_ff <= nxt_done;
      ivec_ff <= nxt_ivec;
    end
  end

  // Bus line decode from state
  assign bus.init  = i_init;
  assign bus.bank7 = (st_ff == M_BS || st_ff == M_SYNC) &&
                     a_ff >= PAGE_HI;
  assign bus.sync  = st_ff inside {M_SYNC, M_DIN, M_DINW, M_DOUT,
                                   M_DOUTW};
  assign bus.din   = st_ff inside {M_DIN, M_IAK};
  assign bus.iak_m = (st_ff == M_IAK);
  assign bus.dout  = (st_ff == M_DOUT);
  // A read-modify-write opens as an input, so no write flag at sync
  assign bus.wtbt  = ((st_ff inside {M_BS, M_SYNC}) && wr_ff && !rmw_ff) ||
                     ((st_ff == M_DOUT) && byte_ff);
  assign bus.dal_m_oe = st_ff inside {M_BS, M_SYNC, M_DOUT};
  assign bus.dal_m_o  = (st_ff == M_DOUT) ? w_ff : a_ff;
  assign o_busy  = (st_ff != M_IDLE);
  assign o_done  = done_ff;
  assign o_ivec  = ivec_ff;
  assign o_rdata = r_ff;
endmodule
`default_nettype wire

// >>> hdl/pbus_pkg.sv
// Constants and types shared by both ends of the parallel bus link
// Notes on behaviour
// - Init clears every attached device's state
// - Request line only when enable and flag
// - Master grants with data-in plus acknowledge
// - Idle device passes acknowledge down chain
// - Requesting device blocks acknowledge, claims grant
// - Bank select marks top page addresses
// - Bank select precedes sync, spans address
// - Sync marks address, held whole transfer
// - Data-in under sync: reply with data
// - Data-in without sync is interrupt acknowledge
// - Data-out: latch data, then reply
// - Write-byte at sync edge announces output
// - Write-byte during data-out selects one byte
// - Lines carry address first, then data
// - Input reads register, output writes it
// - Read-modify-write keeps selection, no readdress
// - Byte write allowed inside read-modify-write
// - Reply drops after data-in drops
// - Address bits 2:1 pick word, bit 0 byte
// - Word or byte writes, word reads only
// - Vector bit 2 set for transmit source
package pbus_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned DAL_W   = 16;
  localparam int unsigned NREG    = 4;
  localparam int unsigned RSEL_LO = 1;
  localparam int unsigned BYTE_B  = 0;
  localparam int unsigned VEC_XMT = 2;
  localparam int unsigned DEV_LO  = 3;
  localparam int unsigned DEV_W   = 10;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] PAGE_HI = 16'he000;

  // Device sequencer states
  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_RD, D_WR, D_HOLD, D_IACK
  } dev_st_t;

  // Master sequencer states
  typedef enum logic [3:0] {
    M_IDLE, M_BS, M_SYNC, M_DIN, M_DINW, M_DOUT, M_DOUTW, M_END,
    M_IAK, M_IAKW
  } mst_st_t;

endpackage

// >>> verification/pbus_props.sv
// Assertion checker watching the bus lines between both ends
`timescale 1ns/10ps
`default_nettype none
module pbus_props
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Master-driven lines
  input wire logic init,
  input wire logic bank7,
  input wire logic sync,
  input wire logic din,
  input wire logic dout,
  input wire logic iak_m,
  input wire logic dal_m_oe,
  // Device-driven lines
  input wire logic irq,
  input wire logic iak_o,
  input wire logic rply,
  input wire logic dal_s_oe
);
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_reply_drops: assert property ($fell(din) |=> !rply)
    else $error("reply held after data-in dropped");
  a_reply_cause: assert property (rply |-> ($past(din) || $past(dout)))
    else $error("reply without a strobe");
  a_lines_freed: assert property (!din && !dout |=> !rply)
    else $error("reply kept after strobes released");
  a_ack_blocked: assert property (irq |-> !iak_o)
    else $error("acknowledge passed while requesting");
  a_ack_passed: assert property (!irq |-> iak_o == iak_m)
    else $error("acknowledge not passed down the chain");
  a_drive_replying: assert property (dal_s_oe |-> rply)
    else $error("device drives data lines without reply");
  a_no_fight: assert property (!(dal_m_oe && dal_s_oe))
    else $error("both ends drive the data lines");
  a_bank_first: assert property ($rose(sync) |-> bank7 && $past(bank7) && dal_m_oe)
    else $error("bank select or address missing at sync");
  a_sync_outlasts: assert property ($fell(sync) |-> !rply && !din && !dout)
    else $error("sync dropped before the transfer ended");
  a_init_quiet: assert property (init |=> !rply && !dal_s_oe)
    else $error("device active during init");
endmodule
`default_nettype wire

// >>> verification/qbus_slave_interface_test.sv
// Self-checking bench for the bus master and device pair
`timescale 1ns/10ps
`default_nettype none
module qbus_slave_interface_test;
  import pbus_pkg::*;

  // Device strapping, arbitrary values
  localparam logic [9:0]  DEV_A = 10'h200;
  localparam logic [5:0]  VBASE = 6'h10;
  localparam logic [15:0] BASE  = {3'b111, DEV_A, 3'b000};

  logic        i_ref_clk, i_rst_b, i_init, i_req, i_wr, i_rmw, i_byte;
  logic        i_prio, o_busy, o_done, o_ivec, o_iak_rx, o_iak_tx, seen;
  logic        i_rx_flag, i_tx_flag, i_rx_ie, i_tx_ie, got_ivec;
  logic [15:0] i_addr, i_wdata, o_rdata;
  logic [15:0] rg [4];
  logic [15:0] m [4];
  int          fail_count, n_tests;

  pbus_if pbus_if_i ();
  pbus_mst pbus_mst_i (.i_ref_clk, .i_rst_b, .bus(pbus_if_i.master),
    .i_init, .i_req, .i_wr, .i_rmw, .i_byte, .i_prio, .i_addr,
    .i_wdata, .o_busy, .o_done, .o_ivec, .o_rdata);
  pbus_dev #(.DEV_ADDR(DEV_A), .VEC_BASE(VBASE)) pbus_dev_i (
    .i_ref_clk, .i_rst_b, .bus(pbus_if_i.device), .o_reg0(rg[0]),
    .o_reg1(rg[1]), .o_reg2(rg[2]), .o_reg3(rg[3]), .i_rx_flag,
    .i_tx_flag, .i_rx_ie, .i_tx_ie, .o_iak_rx, .o_iak_tx);
  pbus_props pbus_props_i (.i_ref_clk, .i_rst_b,
    .init(pbus_if_i.init), .bank7(pbus_if_i.bank7),
    .sync(pbus_if_i.sync), .din(pbus_if_i.din), .dout(pbus_if_i.dout),
    .iak_m(pbus_if_i.iak_m), .dal_m_oe(pbus_if_i.dal_m_oe),
    .irq(pbus_if_i.irq), .iak_o(pbus_if_i.iak_o),
    .rply(pbus_if_i.rply), .dal_s_oe(pbus_if_i.dal_s_oe));

  // 100 MHz clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // User side drops a source once its grant lands
  always @(posedge i_ref_clk)
  begin
    if (o_iak_tx === 1'b1) i_tx_flag <= 1'b0;
    if (o_iak_rx === 1'b1) i_rx_flag <= 1'b0;
    if (o_iak_tx === 1'b1 || o_iak_rx === 1'b1) seen <= 1'b1;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bounded wait, so a lost reply cannot hang the run; it starts at a
  // fresh edge so the last call's done pulse is not taken again, and
  // keeps the vector flag, which leads done by a cycle
  task automatic wait_done;
    int n;
    n = 0;
    got_ivec = 1'b0;
    do
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
      if (o_ivec === 1'b1)
        got_ivec = 1'b1;
    end
    while (o_done !== 1'b1 && n < 100);
    chk({15'h0, o_done}, 16'h0001);
  endtask

  task automatic op(input logic w, r, b, input logic [15:0] a, d);
    @(posedge i_ref_clk);
    i_req <= 1'b1;
    i_wr <= w;
    i_rmw <= r;
    i_byte <= b;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
    wait_done();
    chk({15'h0, got_ivec}, 16'h0000);
  endtask

  task automatic chk_regs;
    for (int k = 0; k < 4; k++)
      chk(rg[k], m[k]);
  endtask

  task automatic final_report;
    $display("compares %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the tests take well under 2000 cycles
  initial
  begin
    #100000;
    fail_count++;
    final_report();
  end

  // Main sequence
  initial
  begin
    {i_rst_b, i_init, i_req, i_wr, i_rmw, i_byte, seen} = '0;
    {i_rx_flag, i_tx_flag, i_rx_ie, i_tx_ie} = '0;
    {i_addr, i_wdata} = '0;
    i_prio = 1'b1;
    fail_count = 0;
    n_tests = 0;
    m = '{default: 16'h0000};
    repeat (12) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    chk_regs();
    for (int k = 0; k < 4; k++)
    begin
      m[k] = {4{4'(k + 3)}};
      op(1'b1, 1'b0, 1'b0, BASE + 16'(2 * k), m[k]);
      op(1'b0, 1'b0, 1'b0, BASE + 16'(2 * k), 16'h0000);
      chk(o_rdata, m[k]);
    end
    chk_regs();
    $display("test word done");
    // Same byte in both lanes, so only the select matters
    op(1'b1, 1'b0, 1'b1, BASE + 16'h0002, 16'ha5a5);
    m[1][7:0] = 8'ha5;
    op(1'b1, 1'b0, 1'b1, BASE + 16'h0007, 16'h3c3c);
    m[3][15:8] = 8'h3c;
    chk_regs();
    op(1'b0, 1'b1, 1'b1, BASE + 16'h0005, 16'h7e7e);
    chk(o_rdata, m[2]);
    m[2][15:8] = 8'h7e;
    chk_regs();
    $display("test byte done");
    // Flags without enable must not request
    @(posedge i_ref_clk);
    i_tx_flag <= 1'b1;
    i_rx_flag <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    chk({15'h0, pbus_if_i.irq}, 16'h0000);
    i_tx_ie <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    chk({15'h0, pbus_if_i.irq}, 16'h0001);
    chk({15'h0, o_busy}, 16'h0000);
    i_prio <= 1'b0;
    wait_done();
    chk({15'h0, got_ivec}, 16'h0001);
    chk(o_rdata, {7'h0, VBASE, 3'b100});
    chk({15'h0, seen}, 16'h0001);
    chk({15'h0, pbus_if_i.irq}, 16'h0000);
    @(posedge i_ref_clk);
    i_rx_ie <= 1'b1;
    seen = 1'b0;
    wait_done();
    chk({15'h0, got_ivec}, 16'h0001);
    chk(o_rdata, {7'h0, VBASE, 3'b000});
    chk({15'h0, seen}, 16'h0001);
    @(posedge i_ref_clk);
    i_prio <= 1'b1;
    $display("test interrupt done");
    i_init <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_init <= 1'b0;
    m = '{default: 16'h0000};
    @(posedge i_ref_clk);
    chk_regs();
    $display("test init done");
    final_report();
  end
endmodule
`default_nettype wire
